// *** inc/adcdc_pkg.sv ***
package adcdc_pkg;
    // Register byte addresses.
    localparam logic [7:0] DSYS_ADDR    = 8'h0C;
    localparam logic [7:0] CLKCFG_ADDR  = 8'h0D;
    localparam logic [7:0] HSTAT_ADDR   = 8'h10;
    // Register reset values.
    localparam logic [7:0] DSYS_RESET   = 8'h3C;
    localparam logic [7:0] CLKCFG_RESET = 8'h08;
    // Writable clock register bits.
    localparam logic [7:0] CLKCFG_WMASK = 8'h8E;
    // Reserved divider code and its stand-in.
    localparam logic [2:0] DIV_RSVD     = 3'h0;
    localparam logic [2:0] DIV_SAFE     = 3'h1;
    // Seed mixed into the command check byte.
    localparam logic [7:0] CHECK_SEED   = 8'h5A;
    // Frame sizes in device words.
    localparam logic [3:0] FIX_WORDS_4CH = 4'h6;
    localparam logic [3:0] FIX_WORDS_2CH = 4'h4;
    localparam logic [3:0] STATUS_WORDS  = 4'h1;
    localparam logic [3:0] CHECK_WORDS   = 4'h1;
    // Clock period and the four delay steps, in ns.
    localparam int CLK_NS  = 4;
    localparam int DLY0_NS = 6;
    localparam int DLY1_NS = 8;
    localparam int DLY2_NS = 10;
    localparam int DLY3_NS = 12;

    // Digital system register layout, bit 7 first.
    typedef struct packed {
        logic       watchdog_timeout_enable;
        logic       crc_all_bits;
        logic [1:0] frame_end_flag_delay;
        logic [1:0] output_float_delay;
        logic       fixed_frame;
        logic       crc_en;
    } adcdc_dsys_t;

    // Clock register layout, bit 7 first.
    typedef struct packed {
        logic       clock_origin_select;
        logic [2:0] rsvd_hi;
        logic [2:0] div_code;
        logic       rsvd_lo;
    } adcdc_clk_t;

    // Host sequencer states.
    typedef enum logic [0:0] {
        HOST_IDLE,
        HOST_RESET
    } adcdc_host_state_t;

    // Least delay rounds up to whole clock cycles.
    function automatic logic [3:0] dly_cycles(input logic [1:0] code);
        int ns;
        ns = (code == 2'h0) ? DLY0_NS : (code == 2'h1) ? DLY1_NS :
             (code == 2'h2) ? DLY2_NS : DLY3_NS;
        return 4'((ns + CLK_NS - 1) / CLK_NS);
    endfunction : dly_cycles

    // Check byte that every command carries.
    function automatic logic [7:0] check_of(input logic [7:0] a, input logic [7:0] d);
        return a ^ d ^ CHECK_SEED;
    endfunction : check_of
endpackage : adcdc_pkg

// *** inc/adcdc_link_if.sv ***
`timescale 1ns/1ps
// Command link from host to converter.
interface adcdc_link_if (
    // Shared clock.
    input wire logic clk
);
    logic       wr;          // One-cycle write strobe.
    logic [7:0] addr;        // Register address.
    logic [7:0] wdata;       // Write data.
    logic [7:0] check;       // Check byte over address and data.
    logic       soft_reset;  // One-cycle software reset.
    logic       reject;      // Device dropped a command.

    // Host end drives commands.
    modport host (
        output wr,
        output addr,
        output wdata,
        output check,
        output soft_reset,
        input  reject
    );

    // Device end takes commands.
    modport device (
        input  wr,
        input  addr,
        input  wdata,
        input  check,
        input  soft_reset,
        output reject
    );
endinterface : adcdc_link_if

// *** design/adcdc_device.sv ***
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// How it works
// - Watchdog counter runs only while enabled.
// - Host resets device after watchdog disable.
// - Checksum coverage mode is bit six.
// - Frame end flag after coded delay.
// - Output floats after coded delay.
// - Fixed or computed words per frame.
// - Checksum word added when enabled.
// - Commands failing the check are ignored while checking is enabled.
// - Internal clock source select bit.
// - Divider by two times code.
// - Sync master drives divided serial clock.
// - Host writes zero to reserved bits.
module adcdc_device #(
    parameter int NCH      = 4,
    parameter int WDT_W    = 16,
    parameter int WDT_LIMIT = 1024
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Command link.
    adcdc_link_if.device          link,
    // Clock pins from outside.
    input  wire logic             external_clock_input,
    input  wire logic             serial_clock_pin,
    // Frame control from the serial engine.
    input  wire logic             sync_master,
    input  wire logic [NCH-1:0]   channel_enable,
    input  wire logic             frame_start,
    input  wire logic             last_bit,
    // Watchdog state.
    output logic                  watchdog_running,
    output logic                  watchdog_timeout,
    // Frame settings.
    output logic                  crc_all_bits,
    output logic                  crc_word_enable,
    output logic [3:0]            frame_words,
    output logic                  frame_end_flag,
    output logic                  dout_oe,
    // Clocks.
    output logic                  internal_div_clock,
    output logic                  sclk_out,
    output logic                  sclk_oe,
    // Register readback.
    output logic [7:0]            dsys_value,
    output logic [7:0]            clk_value
);

    // All flip-flops of the device in one record.
    typedef struct packed {
        adcdc_pkg::adcdc_dsys_t dsys;      // Digital system register.
        adcdc_pkg::adcdc_clk_t  clkc;      // Clock register.
        logic [2:0]             ext_sync;  // Crystal pin synchroniser.
        logic [2:0]             sck_sync;  // Serial clock synchroniser.
        logic [2:0]             div_cnt;   // Source edges this half.
        logic                   div_clk;   // Divided clock level.
        logic                   sclk_o;    // Serial clock pin drive.
        logic                   sclk_oe;   // Serial clock enable.
        logic [WDT_W-1:0]       wdt_cnt;   // Watchdog count.
        logic                   wdt_run;   // Watchdog active.
        logic                   wdt_to;    // Watchdog expired.
        logic [3:0]             fend_cnt;  // Frame end delay count.
        logic                   fend_flag; // Frame end flag.
        logic [3:0]             flt_cnt;   // Float delay count.
        logic                   dout_oe;   // Data output enable.
        logic [3:0]             words;     // Words per frame.
        logic                   reject;    // Command dropped.
    } adcdc_dev_st_t;

    adcdc_dev_st_t st;       // Current state.
    adcdc_dev_st_t next_st;  // Next state.

    // Every output comes straight from a flip-flop.
    assign watchdog_running   = st.wdt_run;
    assign watchdog_timeout   = st.wdt_to;
    assign crc_all_bits       = st.dsys.crc_all_bits;
    assign crc_word_enable    = st.dsys.crc_en;
    assign frame_words        = st.words;
    assign frame_end_flag     = st.fend_flag;
    assign dout_oe            = st.dout_oe;
    assign internal_div_clock = st.div_clk;
    assign sclk_out           = st.sclk_o;
    assign sclk_oe            = st.sclk_oe;
    assign dsys_value         = st.dsys;
    assign clk_value          = st.clkc;
    assign link.reject        = st.reject;

    // Next state of the whole device.
    always_comb begin
        logic       check_ok;  // Command check passed.
        logic       src_edge;  // Rising edge of selected source.
        logic [2:0] half;      // Source edges per half period.
        logic [3:0] nwords;    // Computed frame size.
        check_ok = 1'b0;
        src_edge = 1'b0;
        half     = adcdc_pkg::DIV_SAFE;
        nwords   = 4'h0;
        next_st  = st;
        next_st.reject = 1'b0;

        // Stage two reads only stage one; edges look at later stages.
        next_st.ext_sync = {st.ext_sync[1:0], external_clock_input};
        next_st.sck_sync = {st.sck_sync[1:0], serial_clock_pin};

        // A software reset restores both registers before any write.
        // Soft reset resync
        if (link.soft_reset) begin
            next_st.dsys    = adcdc_pkg::adcdc_dsys_t'(adcdc_pkg::DSYS_RESET);
            next_st.clkc    = adcdc_pkg::adcdc_clk_t'(adcdc_pkg::CLKCFG_RESET);
            next_st.wdt_cnt = '0;
            next_st.div_cnt = 3'h0;
        end

        // With checking on, only good commands land.
        // Drop failed commands
        check_ok = !st.dsys.crc_en ||
                   (link.check == adcdc_pkg::check_of(link.addr, link.wdata));
        if (link.wr) begin
            if (!check_ok) begin
                next_st.reject = 1'b1;
            end else if (link.addr == adcdc_pkg::DSYS_ADDR) begin
                next_st.dsys = adcdc_pkg::adcdc_dsys_t'(link.wdata);
            end else if (link.addr == adcdc_pkg::CLKCFG_ADDR) begin
                // Reserved bits stay zero.
                // Reserved bits zero
                next_st.clkc = adcdc_pkg::adcdc_clk_t'(link.wdata &
                                                       adcdc_pkg::CLKCFG_WMASK);
            end
        end

        // The watchdog counts between frames and stops when disabled.
        // Watchdog enable gate
        next_st.wdt_run = st.dsys.watchdog_timeout_enable;
        if (!st.dsys.watchdog_timeout_enable) begin
            next_st.wdt_cnt = '0;
            next_st.wdt_to  = 1'b0;
        end else if (frame_start) begin
            next_st.wdt_cnt = '0;
            next_st.wdt_to  = 1'b0;
        end else if (st.wdt_cnt == WDT_W'(WDT_LIMIT - 1)) begin
            // Expiry is sticky until the next frame starts or the watchdog is disabled.
            next_st.wdt_to = 1'b1;
        end else begin
            next_st.wdt_cnt = st.wdt_cnt + WDT_W'(1);
        end

        // Frame end flag rises the coded delay after the last bit.
        // Frame end delay
        if (frame_start) begin
            next_st.fend_flag = 1'b0;
        end
        if (last_bit) begin
            next_st.fend_cnt =
                adcdc_pkg::dly_cycles(st.dsys.frame_end_flag_delay);
        end else if (st.fend_cnt != 4'h0) begin
            next_st.fend_cnt = st.fend_cnt - 4'h1;
            // A new flag beats a clear in the same cycle.
            if (st.fend_cnt == 4'h1) begin
                next_st.fend_flag = 1'b1;
            end
        end

        // Output floats the coded delay after the last bit.
        // Float delay
        if (frame_start) begin
            next_st.dout_oe = 1'b1;
        end
        if (last_bit) begin
            next_st.flt_cnt =
                adcdc_pkg::dly_cycles(st.dsys.output_float_delay);
        end else if (st.flt_cnt != 4'h0) begin
            next_st.flt_cnt = st.flt_cnt - 4'h1;
            if (st.flt_cnt == 4'h1 && !frame_start) begin
                next_st.dout_oe = 1'b0;
            end
        end

        // Frame size is fixed or follows the enabled words.
        // Words per frame
        nwords = adcdc_pkg::STATUS_WORDS;
        for (int i = 0; i < NCH; i++) begin
            nwords = nwords + {3'h0, channel_enable[i]};
        end
        if (st.dsys.crc_en) begin
            nwords = nwords + adcdc_pkg::CHECK_WORDS;
        end
        if (st.dsys.fixed_frame) begin
            nwords = (NCH == 4) ? adcdc_pkg::FIX_WORDS_4CH
                                : adcdc_pkg::FIX_WORDS_2CH;
        end
        next_st.words = nwords;

        // Pick the source edge for the internal clock.
        // Clock source select
        src_edge = st.clkc.clock_origin_select ?
                   (st.sck_sync[1] && !st.sck_sync[2]) :
                   (st.ext_sync[1] && !st.ext_sync[2]);

        // Toggling every code edges divides by twice the code.
        // The reserved code runs as the smallest ratio, not a stall.
        // Divide by code
        if (st.clkc.div_code != adcdc_pkg::DIV_RSVD) begin
            half = st.clkc.div_code;
        end
        if (src_edge) begin
            if (st.div_cnt + 3'h1 >= half) begin
                next_st.div_cnt = 3'h0;
                next_st.div_clk = !st.div_clk;
            end else begin
                next_st.div_cnt = st.div_cnt + 3'h1;
            end
        end

        // As master the divided clock drives the serial clock.
        // Master clock out
        next_st.sclk_oe = sync_master;
        next_st.sclk_o  = sync_master && next_st.div_clk;
    end

    // Register the record; reset loads constants only.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st      <= '0;
            st.dsys <= adcdc_pkg::adcdc_dsys_t'(adcdc_pkg::DSYS_RESET);
            st.clkc <= adcdc_pkg::adcdc_clk_t'(adcdc_pkg::CLKCFG_RESET);
        end else begin
            st <= next_st;
        end
    end

endmodule : adcdc_device

// *** design/adcdc_host.sv ***
`timescale 1ns/1ps
// Host end: software port in, link commands out.
module adcdc_host (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Command link.
    adcdc_link_if.host      link,
    // Software register port.
    input  wire logic [7:0] sw_addr,
    input  wire logic [7:0] sw_wdata,
    input  wire logic       sw_wr,
    input  wire logic       sw_rd,
    output logic [7:0]      sw_rdata
);

    // All flip-flops of the host in one record.
    typedef struct packed {
        adcdc_pkg::adcdc_dsys_t       dsys;    // Shadow of device register.
        adcdc_pkg::adcdc_clk_t        clkc;    // Shadow of clock register.
        adcdc_pkg::adcdc_host_state_t state;   // Sequencer state.
        logic                         wr;      // Link write strobe.
        logic [7:0]                   addr;    // Link address.
        logic [7:0]                   wdata;   // Link data.
        logic [7:0]                   check;   // Link check byte.
        logic                         sreset;  // Link soft reset.
        logic                         rej;     // Sticky reject seen.
        logic [7:0]                   rdata;   // Software read data.
    } adcdc_host_st_t;

    adcdc_host_st_t st;       // Current state.
    adcdc_host_st_t next_st;  // Next state.

    // Outputs straight from flip-flops.
    assign link.wr         = st.wr;
    assign link.addr       = st.addr;
    assign link.wdata      = st.wdata;
    assign link.check      = st.check;
    assign link.soft_reset = st.sreset;
    assign sw_rdata        = st.rdata;

    // Next state of the host.
    always_comb begin
        adcdc_pkg::adcdc_clk_t cnew;  // Clock write, reserved bits cleared.
        cnew    = adcdc_pkg::adcdc_clk_t'(sw_wdata & adcdc_pkg::CLKCFG_WMASK);
        next_st = st;
        next_st.wr     = 1'b0;
        next_st.sreset = 1'b0;
        next_st.rdata  = 8'h00;

        // A reset follows the write that turned the watchdog off.
        // The shadows go back to defaults in step with the device.
        unique case (st.state)
            adcdc_pkg::HOST_IDLE: begin
            end
            adcdc_pkg::HOST_RESET: begin
                next_st.sreset = 1'b1;
                next_st.dsys   = adcdc_pkg::adcdc_dsys_t'(adcdc_pkg::DSYS_RESET);
                next_st.clkc   = adcdc_pkg::adcdc_clk_t'(adcdc_pkg::CLKCFG_RESET);
                next_st.state  = adcdc_pkg::HOST_IDLE;
            end
        endcase

        // Software writes to the two registers become link commands; other addresses are dropped.
        if (sw_wr && sw_addr == adcdc_pkg::DSYS_ADDR) begin
            next_st.wr    = 1'b1;
            next_st.addr  = sw_addr;
            next_st.wdata = sw_wdata;
            next_st.dsys  = adcdc_pkg::adcdc_dsys_t'(sw_wdata);
            if (st.dsys.watchdog_timeout_enable && !next_st.dsys.watchdog_timeout_enable) begin
                next_st.state = adcdc_pkg::HOST_RESET;
            end
        end else if (sw_wr && sw_addr == adcdc_pkg::CLKCFG_ADDR) begin
            // Reserved code keeps the old divider.
            // Never send reserved code
            if (cnew.div_code == adcdc_pkg::DIV_RSVD) begin
                cnew.div_code = st.clkc.div_code;
            end
            next_st.wr    = 1'b1;
            next_st.addr  = sw_addr;
            next_st.wdata = cnew;
            next_st.clkc  = cnew;
        end
        next_st.check = adcdc_pkg::check_of(next_st.addr, next_st.wdata);

        // Reads answer from the shadows one cycle later.
        if (sw_rd) begin
            if (sw_addr == adcdc_pkg::DSYS_ADDR) begin
                next_st.rdata = st.dsys;
            end else if (sw_addr == adcdc_pkg::CLKCFG_ADDR) begin
                next_st.rdata = st.clkc;
            end else if (sw_addr == adcdc_pkg::HSTAT_ADDR) begin
                next_st.rdata = {7'h00, st.rej};
                next_st.rej   = 1'b0;
            end
        end
        // A reject in the clearing cycle is kept.
        if (link.reject) begin
            next_st.rej = 1'b1;
        end
    end

    // Register the record; reset loads constants only.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st       <= '0;
            st.dsys  <= adcdc_pkg::adcdc_dsys_t'(adcdc_pkg::DSYS_RESET);
            st.clkc  <= adcdc_pkg::adcdc_clk_t'(adcdc_pkg::CLKCFG_RESET);
            st.state <= adcdc_pkg::HOST_IDLE;
        end else begin
            st <= next_st;
        end
    end

endmodule : adcdc_host

// *** tb/adcdc_link_asserts.sv ***
`timescale 1ns/1ps
// Link and readback checks of the device end.
module adcdc_link_asserts (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rst_b,
    // Link signals.
    input wire logic       wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] check,
    input wire logic       soft_reset,
    input wire logic       reject,
    // Device readback.
    input wire logic [7:0] dsys_value,
    input wire logic [7:0] clk_value,
    input wire logic       watchdog_running
);
    // One clock domain.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_rsvd_zero;
        wr && addr == adcdc_pkg::CLKCFG_ADDR |-> wdata[6:4] == 3'h0 && !wdata[0];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
    property p_div_legal;
        wr && addr == adcdc_pkg::CLKCFG_ADDR |-> wdata[3:1] != 3'h0;
    endproperty
    a_div_legal: assert property (p_div_legal) else $error("reserved divider");
    property p_check_byte;
        wr |-> check == (addr ^ wdata ^ adcdc_pkg::CHECK_SEED);
    endproperty
    a_check_byte: assert property (p_check_byte) else $error("bad check");
    property p_no_reject;
        wr |=> !reject;
    endproperty
    a_no_reject: assert property (p_no_reject) else $error("good command dropped");
    property p_dsys_write;
        wr && addr == adcdc_pkg::DSYS_ADDR |=> dsys_value == $past(wdata);
    endproperty
    a_dsys_write: assert property (p_dsys_write) else $error("system write lost");
    property p_clk_write;
        wr && addr == adcdc_pkg::CLKCFG_ADDR |=> clk_value == $past(wdata);
    endproperty
    a_clk_write: assert property (p_clk_write) else $error("clock write lost");
    property p_soft_defaults;
        soft_reset && !wr |=> dsys_value == adcdc_pkg::DSYS_RESET
            && clk_value == adcdc_pkg::CLKCFG_RESET;
    endproperty
    a_soft_defaults: assert property (p_soft_defaults) else $error("no defaults");
    // The host must follow a watchdog disable with a reset.
    property p_wdt_off_reset;
        wr && addr == adcdc_pkg::DSYS_ADDR && dsys_value[7] && !wdata[7] |=> soft_reset;
    endproperty
    a_wdt_off_reset: assert property (p_wdt_off_reset) else $error("no reset");
    property p_wdt_running;
        $changed(dsys_value[7]) |=> watchdog_running == $past(dsys_value[7]);
    endproperty
    a_wdt_running: assert property (p_wdt_running) else $error("watchdog state");
endmodule : adcdc_link_asserts

// *** tb/adc_digital_cfg_clock_regs_tb_top.sv ***
`timescale 1ns/1ps
// Host and device on one link; a spare device driven by the bench.
module adc_digital_cfg_clock_regs_tb_top;
    localparam int WDT = 8;  // Short limit keeps the run brief.
    localparam logic [7:0] DSYS_A = adcdc_pkg::DSYS_ADDR, CLK_A = adcdc_pkg::CLKCFG_ADDR;
    logic       clk, rst_b, sw_wr, sw_rd, ext_clk = 1'b0, ser_clk = 1'b0, src_sel, sync_master;
    logic       frame_start, last_bit, wd_run, wd_to, crc_all, crc_word, fe_flag;
    logic       dout_oe, div_clk, sclk_out, sclk_oe;
    logic [7:0] sw_addr, sw_wdata, sw_rdata, got, dsys, clkv, dsys_b, clkv_b;
    logic [7:0] m_dsys, m_clk;  // Bench model of both registers.
    logic [3:0] chan_en, words, src_cnt = 4'h0;
    int         miscompares, num_checks, cycles = 0;

    adcdc_link_if link_a (.clk(clk));
    adcdc_link_if link_b (.clk(clk));
    adcdc_host adcdc_host_inst (.clk(clk), .rst_b(rst_b), .link(link_a), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    adcdc_device #(.NCH(4), .WDT_LIMIT(WDT)) adcdc_device_inst (.clk(clk), .rst_b(rst_b),
        .link(link_a), .external_clock_input(ext_clk), .serial_clock_pin(ser_clk),
        .sync_master(sync_master), .channel_enable(chan_en), .frame_start(frame_start),
        .last_bit(last_bit), .watchdog_running(wd_run), .watchdog_timeout(wd_to),
        .crc_all_bits(crc_all), .crc_word_enable(crc_word), .frame_words(words),
        .frame_end_flag(fe_flag), .dout_oe(dout_oe), .internal_div_clock(div_clk),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .dsys_value(dsys), .clk_value(clkv));
    // Spare device takes broken commands.
    adcdc_device #(.NCH(4), .WDT_LIMIT(WDT)) adcdc_device_inst_b (.clk(clk), .rst_b(rst_b),
        .link(link_b), .external_clock_input(ext_clk), .serial_clock_pin(ser_clk),
        .sync_master(sync_master), .channel_enable(chan_en), .frame_start(frame_start),
        .last_bit(last_bit), .watchdog_running(), .watchdog_timeout(), .crc_all_bits(),
        .crc_word_enable(), .frame_words(), .frame_end_flag(), .dout_oe(),
        .internal_div_clock(), .sclk_out(), .sclk_oe(), .dsys_value(dsys_b), .clk_value(clkv_b));
    adcdc_link_asserts adcdc_link_asserts_inst (.clk(clk), .rst_b(rst_b), .wr(link_a.wr),
        .addr(link_a.addr), .wdata(link_a.wdata), .check(link_a.check),
        .soft_reset(link_a.soft_reset), .reject(link_a.reject), .dsys_value(dsys),
        .clk_value(clkv), .watchdog_running(wd_run));

    // Free-running clock of 4 ns.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Source clock of four cycles on the selected pin only.
    always @(posedge clk) begin
        src_cnt <= src_cnt + 4'h1;
        ext_clk <= !src_sel && src_cnt[1];
        ser_clk <= src_sel && src_cnt[1];
        cycles  <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    function automatic logic [7:0] exp_clk(input logic [7:0] old, input logic [7:0] d);
        return {d[7], 3'h0, (d[3:1] == 3'h0) ? old[3:1] : d[3:1], 1'b0};
    endfunction : exp_clk

    function automatic logic [3:0] exp_words(input logic [7:0] d, input logic [3:0] ch);
        return d[1] ? 4'h6 : 4'(1 + $countones(ch) + d[0]);
    endfunction : exp_words

    // Least delay in ns rounded up to whole cycles.
    function automatic logic [7:0] exp_dly(input int c);
        return 8'((6 + 2 * c + 3) / 4);
    endfunction : exp_dly

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_wr    <= 1'b1;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : sw_write

    task automatic sw_read(input logic [7:0] a);
        @(posedge clk);
        sw_rd   <= 1'b1;
        sw_addr <= a;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1;
        got = sw_rdata;
    endtask : sw_read

    task automatic b_write(input logic [7:0] a, input logic [7:0] d, input logic ok);
        logic [7:0] r = 8'h00;
        @(posedge clk);
        link_b.wr    <= 1'b1;
        link_b.addr  <= a;
        link_b.wdata <= d;
        link_b.check <= a ^ d ^ adcdc_pkg::CHECK_SEED ^ {7'h0, !ok};
        @(posedge clk);
        link_b.wr <= 1'b0;
        repeat (3) begin
            #1;
            r = r + link_b.reject;
            @(posedge clk);
        end
        chk(r, {7'h0, !ok});
    endtask : b_write

    // Lets a write land, then compares all register outputs.
    task automatic verify();
        repeat (3) @(posedge clk);
        #1;
        chk(dsys, m_dsys);
        chk(clkv, m_clk);
        chk(crc_all, m_dsys[6]);
        chk(crc_word, m_dsys[0]);
        chk(words, exp_words(m_dsys, chan_en));
        chk(wd_run, m_dsys[7]);
        sw_read(DSYS_A);
        chk(got, m_dsys);
        sw_read(CLK_A);
        chk(got, m_clk);
    endtask : verify

    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    initial begin
        logic [7:0] a, d;
        int         kf, ko, t, ts;
        {rst_b, sw_wr, sw_rd, sw_addr, sw_wdata, src_sel} = '0;
        {sync_master, frame_start, last_bit} = '0;
        {link_b.wr, link_b.addr, link_b.wdata, link_b.check, link_b.soft_reset} = '0;
        chan_en = 4'hF;
        m_dsys  = adcdc_pkg::DSYS_RESET;
        m_clk   = adcdc_pkg::CLKCFG_RESET;
        void'($urandom(34));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        verify();
        sw_read(8'h0E);
        chk(got, 8'h00);
        sw_read(adcdc_pkg::HSTAT_ADDR);
        chk(got, 8'h00);
        // Random writes, some unmapped, one with a reserved divider.
        for (int i = 0; i < 24; i++) begin
            t = $urandom % 3;
            a = (t == 0) ? DSYS_A : (t == 1) ? CLK_A : 8'h40;
            d = 8'($urandom);
            if (i == 0) {a, d} = {CLK_A, 8'hF1};
            if (a == DSYS_A) begin
                d[7]   = 1'b0;
                m_dsys = d;
            end
            if (a == CLK_A) begin
                m_clk = exp_clk(m_clk, d);
            end
            @(posedge clk);
            chan_en <= 4'($urandom);
            sw_write(a, d);
            verify();
        end
        m_dsys = 8'hBC;
        sw_write(DSYS_A, m_dsys);
        verify();
        repeat (WDT + 4) @(posedge clk);
        #1;
        chk(wd_to, 1'b1);
        @(posedge clk);
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        @(posedge clk);
        #1;
        chk(wd_to, 1'b0);
        sw_write(CLK_A, 8'h8A);
        sw_write(DSYS_A, 8'h3D);
        m_dsys = adcdc_pkg::DSYS_RESET;
        m_clk  = adcdc_pkg::CLKCFG_RESET;
        verify();
        // flag and float delays per code
        for (int c = 0; c < 4; c++) begin
            m_dsys = {2'b00, 2'(c), 2'(c), 2'b00};
            sw_write(DSYS_A, m_dsys);
            verify();
            @(posedge clk);
            frame_start <= 1'b1;
            @(posedge clk);
            frame_start <= 1'b0;
            last_bit    <= 1'b1;
            @(posedge clk);
            last_bit <= 1'b0;
            {kf, ko} = '0;
            for (int k = 1; k < 9; k++) begin
                @(posedge clk);
                #1;
                kf = (kf == 0 && fe_flag === 1'b1) ? k : kf;
                ko = (ko == 0 && dout_oe === 1'b0) ? k : ko;
            end
            chk(8'(kf), exp_dly(c));
            chk(8'(ko), exp_dly(c));
        end
        for (int code = 1; code < 8; code++) begin
            m_clk = {code[1], 3'h0, 3'(code), 1'b0};
            sw_write(CLK_A, m_clk);
            verify();
            @(posedge clk);
            src_sel     <= code[1];
            sync_master <= 1'b1;
            repeat (40) @(posedge clk);
            t  = 0;
            ts = 0;
            repeat (32 * code) begin
                a = {6'h0, div_clk, sclk_out};
                @(posedge clk);
                #1;
                t += int'(div_clk !== a[1]);
                ts += int'(sclk_out !== a[0]);
            end
            chk(t >= 7 && t <= 9, 1'b1);
            chk(ts >= 7 && ts <= 9, 1'b1);
            chk(sclk_oe, 1'b1);
        end
        // spare device drops a bad-check write
        b_write(DSYS_A, 8'h3D, 1'b1);
        b_write(DSYS_A, 8'h11, 1'b0);
        chk(dsys_b, 8'h3D);
        b_write(CLK_A, 8'hF1, 1'b1);
        chk(clkv_b & 8'hF1, 8'h80);
        end_of_test();
    end
endmodule : adc_digital_cfg_clock_regs_tb_top
